// *** include/ltu_pkg.sv ***
// Constants for the ladder timer unit: register map, field layout, BCD limits, timing.
// Assumes a single 200 MHz clock and a classic Wishbone slave port with 32-bit data.
// Function
// - Single-input timer advances once per tick while its input is on.
// - Single-input timer clears to zero when its input turns off.
// - Standard single-input timer steps 0.1 s, tops out at 999.9 s.
// - Fast single-input timer steps 0.01 s, tops out at 99.99 s.
// - Done bit is on when current value is at or above preset and the timer is not held at zero.
// - Single-input preset is a constant 0-9999 or a chosen memory word.
// - Constant presets may be rewritten while running; memory presets for program changes.
// - Accumulating timer advances only while enabled, keeps its value when disabled.
// - Re-enabled accumulating timer resumes from its held value.
// - Accumulating timer held at zero while its reset input is on.
// - Standard accumulating timer steps 0.1 s up to 9999999.9.
// - Fast accumulating timer steps 0.01 s up to 999999.99.
// - Accumulating value is 8 digits over two timer words; preset 0-99999999.
// - Timer value readable at the data word whose address is its number.
// - Resetting a timer clears the value; done_o and the done word clear one cycle later.
`default_nettype none

package ltu_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int unsigned NUM_CHAN  = 4;     // Timer channels, two timer numbers each
    localparam int unsigned NUM_WORDS = 8;     // Timer numbers / value words
    localparam int unsigned NUM_PMEM  = 8;     // Preset memory words
    localparam int unsigned DIGITS    = 8;     // BCD digits per channel

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam longint unsigned CLK_PERIOD_PS = 64'd5000;        // 5 ns
    localparam longint unsigned HUND_STEP_PS  = 64'd10000000000; // 0.01 s step
    localparam int unsigned HUND_CYC =
        int'((HUND_STEP_PS + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS);
    localparam int unsigned HUND_PER_TENTH = 10; // 0.01 s ticks per 0.1 s tick
    localparam int unsigned HUND_CNT_W     = 21;
    localparam int unsigned TENTH_CNT_W    = 4;

    ////////////////////////////////////////////////////////////////////////////
    // BCD limits
    localparam logic [3:0]  DIGIT_NINE      = 4'h9;
    localparam logic [3:0]  DIGIT_ZERO      = 4'h0;
    localparam logic [3:0]  DIGIT_ONE       = 4'h1;
    localparam logic [31:0] VAL_ZERO        = 32'h0000_0000;
    localparam logic [31:0] SGL_MAX         = 32'h0000_9999; // 999.9 / 99.99
    localparam logic [31:0] ACC_MAX         = 32'h9999_9999; // 9999999.9 / 999999.99
    localparam logic [31:0] SGL_PRESET_MASK = 32'h0000_ffff; // Four digits only

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_DONE   = 8'h04;
    localparam logic [7:0] OFS_CFG    = 8'h10; // + 4 * channel
    localparam logic [7:0] OFS_PCONST = 8'h20; // + 4 * channel
    localparam logic [7:0] OFS_PMEM   = 8'h40; // + 4 * word
    localparam logic [7:0] OFS_VALUE  = 8'h80; // + 4 * timer number
    localparam logic [7:0] WORD_STEP  = 8'h04;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned CTRL_RUN_LSB = 0;  // Input / enable per channel
    localparam int unsigned CTRL_CLR_LSB = 8;  // Accumulator reset per channel
    localparam int unsigned CFG_ACCUM    = 0;
    localparam int unsigned CFG_FAST     = 1;
    localparam int unsigned CFG_MEMSRC   = 2;
    localparam int unsigned CFG_IDX_LSB  = 3;
    localparam int unsigned CFG_W        = 6;
    localparam logic [CFG_W-1:0] CFG_RST = 6'h00;
    localparam logic [31:0]      REG_RST = 32'h0000_0000;

endpackage : ltu_pkg

`default_nettype wire

// *** src/ltu_tick_div.sv ***
// One-cycle tick divider: pulses once every DIV enabled cycles.
// Assumes en_i is a one-cycle enable in the clk_i domain.
`default_nettype none

module ltu_tick_div #(
    parameter int unsigned CNT_W = 4,
    parameter int unsigned DIV   = 10
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Enable in, tick out
    input  wire logic en_i,
    output logic      tick_o
);

    localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);
    localparam logic [CNT_W-1:0] ZERO = '0;
    localparam logic [CNT_W-1:0] ONE  = CNT_W'(1);

    logic [CNT_W-1:0] cnt_r;

    ////////////////////////////////////////////////////////////////////////////
    // Count enables, wrap and pulse at the last one
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_r  <= ZERO;
            tick_o <= 1'b0;
        end
        else
        begin
            tick_o <= en_i && (cnt_r == LAST);
            if (en_i)
            begin
                cnt_r <= (cnt_r == LAST) ? ZERO : cnt_r + ONE;
            end
        end
    end

endmodule // ltu_tick_div

`default_nettype wire

// *** src/ltu_timer_chan.sv ***
// One timer channel: single-input or accumulating, 0.1 s or 0.01 s step, BCD value.
// Assumes tick inputs are one-cycle pulses and preset_i is packed BCD.
`default_nettype none

module ltu_timer_chan (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Time base
    input  wire logic        tick_tenth_i,
    input  wire logic        tick_hund_i,
    // Mode
    input  wire logic        accum_i,
    input  wire logic        fast_i,
    // Timer inputs from the scan
    input  wire logic        run_i,
    input  wire logic        clear_i,
    input  wire logic [31:0] preset_i,
    // Results
    output logic [31:0]      value_o,
    output logic             done_o
);

    logic        tick;
    logic        hold_zero;
    logic [31:0] max_val;
    logic [31:0] preset_eff;
    logic [31:0] value_nxt;
    logic        done_nxt;

    // Decimal increment with carry from digit to digit
    function automatic logic [31:0] bcd_inc(input logic [31:0] v);
        logic [31:0] r;
        logic        c;
        r = v;
        c = 1'b1;
        for (int i = 0; i < int'(ltu_pkg::DIGITS); i++)
        begin
            if (c)
            begin
                if (r[4*i +: 4] == ltu_pkg::DIGIT_NINE)
                begin
                    r[4*i +: 4] = ltu_pkg::DIGIT_ZERO;
                end
                else
                begin
                    r[4*i +: 4] = r[4*i +: 4] + ltu_pkg::DIGIT_ONE;
                    c = 1'b0;
                end
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next value and done
    always_comb
    begin
        tick       = fast_i ? tick_hund_i : tick_tenth_i;
        max_val    = accum_i ? ltu_pkg::ACC_MAX : ltu_pkg::SGL_MAX;
        preset_eff = accum_i ? preset_i
                             : (preset_i & ltu_pkg::SGL_PRESET_MASK);
        hold_zero  = accum_i ? clear_i : !run_i;
        value_nxt  = value_o;
        if (hold_zero)
        begin
            value_nxt = ltu_pkg::VAL_ZERO;
        end
        else if (run_i && tick && (value_o < max_val))
        begin
            value_nxt = bcd_inc(value_o);
        end
        done_nxt = !hold_zero && (value_nxt >= preset_eff);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Value and done update together
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            value_o <= ltu_pkg::VAL_ZERO;
            done_o  <= 1'b0;
        end
        else
        begin
            value_o <= value_nxt;
            done_o  <= done_nxt;
        end
    end

endmodule // ltu_timer_chan

`default_nettype wire

// *** src/ltu_top.sv ***
// Ladder timer unit top: Wishbone register file, time base and four timer channels.
// Assumes a classic Wishbone master on clk_i and the ladder scan writing inputs via CTRL.
`default_nettype none

module ltu_top #(
    parameter int unsigned HUND_CYC = ltu_pkg::HUND_CYC
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Timer done bits
    output logic [3:0]       done_o
);

    localparam int unsigned NC = ltu_pkg::NUM_CHAN;
    localparam int unsigned NW = ltu_pkg::NUM_WORDS;
    localparam int unsigned NP = ltu_pkg::NUM_PMEM;
    localparam int unsigned CW = ltu_pkg::CFG_W;

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    logic [NC-1:0]   run_r;
    logic [NC-1:0]   clr_r;
    logic [CW-1:0]   cfg_r    [NC];
    logic [31:0]     pconst_r [NC];
    logic [31:0]     pmem_r   [NP];
    logic [31:0]     chan_val [NC];
    logic [NC-1:0]   chan_done;
    logic [31:0]     preset   [NC];
    logic            tick_hund;
    logic            tick_tenth;

    // Bus decode
    logic            req;
    logic            wr;
    logic            wr_ctrl;
    logic [NC-1:0]   wr_cfg;
    logic [NC-1:0]   wr_pconst;
    logic [NP-1:0]   wr_pmem;
    logic [31:0]     rd_data;
    logic [31:0]     ctrl_word;

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Byte address of element k of a register group
    function automatic logic [7:0] slot_adr(input logic [7:0] base, input int unsigned k);
        return base + 8'(k * 4);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Time base: 0.01 s from the clock, 0.1 s from ten of those
    ltu_tick_div #(
        .CNT_W (ltu_pkg::HUND_CNT_W),
        .DIV   (HUND_CYC)
    ) u_div_hund (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .en_i   (1'b1),
        .tick_o (tick_hund)
    );

    ltu_tick_div #(
        .CNT_W (ltu_pkg::TENTH_CNT_W),
        .DIV   (ltu_pkg::HUND_PER_TENTH)
    ) u_div_tenth (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .en_i   (tick_hund),
        .tick_o (tick_tenth)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Timer channels, each owning timer numbers 2k and 2k+1
    for (genvar k = 0; k < NC; k++)
    begin : g_chan
        // Preset from constant or from a chosen preset memory word
        assign preset[k] = cfg_r[k][ltu_pkg::CFG_MEMSRC]
                         ? pmem_r[cfg_r[k][CW-1:ltu_pkg::CFG_IDX_LSB]]
                         : pconst_r[k];

        ltu_timer_chan u_chan (
            .clk_i        (clk_i),
            .rst_i        (rst_i),
            .tick_tenth_i (tick_tenth),
            .tick_hund_i  (tick_hund),
            .accum_i      (cfg_r[k][ltu_pkg::CFG_ACCUM]),
            .fast_i       (cfg_r[k][ltu_pkg::CFG_FAST]),
            .run_i        (run_r[k]),
            .clear_i      (clr_r[k]),
            .preset_i     (preset[k]),
            .value_o      (chan_val[k]),
            .done_o       (chan_done[k])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write decode, taken in the request cycle, before the answer is issued
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr  = req && wb_we_i;

    always_comb
    begin
        wr_ctrl   = wr && (wb_adr_i == ltu_pkg::OFS_CTRL);
        wr_cfg    = '0;
        wr_pconst = '0;
        wr_pmem   = '0;
        for (int unsigned k = 0; k < NC; k++)
        begin
            wr_cfg[k]    = wr && (wb_adr_i == slot_adr(ltu_pkg::OFS_CFG, k));
            wr_pconst[k] = wr && (wb_adr_i == slot_adr(ltu_pkg::OFS_PCONST, k));
        end
        for (int unsigned w = 0; w < NP; w++)
        begin
            wr_pmem[w] = wr && (wb_adr_i == slot_adr(ltu_pkg::OFS_PMEM, w));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timer inputs and accumulator resets, as written by the scan
    assign ctrl_word = merge({16'h0000, 4'h0, clr_r, 4'h0, run_r},
                             wb_dat_i, wb_sel_i);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            run_r <= '0;
            clr_r <= '0;
        end
        else if (wr_ctrl)
        begin
            run_r <= ctrl_word[ltu_pkg::CTRL_RUN_LSB +: NC];
            clr_r <= ctrl_word[ltu_pkg::CTRL_CLR_LSB +: NC];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel configuration and constant presets, writable at any time
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int unsigned k = 0; k < NC; k++)
            begin
                cfg_r[k]    <= ltu_pkg::CFG_RST;
                pconst_r[k] <= ltu_pkg::REG_RST;
            end
        end
        else
        begin
            for (int unsigned k = 0; k < NC; k++)
            begin
                if (wr_cfg[k] && wb_sel_i[0])
                begin
                    cfg_r[k] <= wb_dat_i[CW-1:0];
                end
                if (wr_pconst[k])
                begin
                    pconst_r[k] <= merge(pconst_r[k], wb_dat_i, wb_sel_i);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Preset memory words
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int unsigned w = 0; w < NP; w++)
            begin
                pmem_r[w] <= ltu_pkg::REG_RST;
            end
        end
        else
        begin
            for (int unsigned w = 0; w < NP; w++)
            begin
                if (wr_pmem[w])
                begin
                    pmem_r[w] <= merge(pmem_r[w], wb_dat_i, wb_sel_i);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read zero
    always_comb
    begin
        rd_data = ltu_pkg::REG_RST;
        if (wb_adr_i == ltu_pkg::OFS_CTRL)
        begin
            rd_data[ltu_pkg::CTRL_RUN_LSB +: NC] = run_r;
            rd_data[ltu_pkg::CTRL_CLR_LSB +: NC] = clr_r;
        end
        if (wb_adr_i == ltu_pkg::OFS_DONE)
        begin
            rd_data[NC-1:0] = done_o;
        end
        for (int unsigned k = 0; k < NC; k++)
        begin
            if (wb_adr_i == slot_adr(ltu_pkg::OFS_CFG, k))
            begin
                rd_data[CW-1:0] = cfg_r[k];
            end
            if (wb_adr_i == slot_adr(ltu_pkg::OFS_PCONST, k))
            begin
                rd_data = pconst_r[k];
            end
        end
        for (int unsigned w = 0; w < NP; w++)
        begin
            if (wb_adr_i == slot_adr(ltu_pkg::OFS_PMEM, w))
            begin
                rd_data = pmem_r[w];
            end
        end
        // Value word n: low four digits at the even number, high four at the odd for an accumulating channel, else zero
        for (int unsigned n = 0; n < NW; n++)
        begin
            if (wb_adr_i == slot_adr(ltu_pkg::OFS_VALUE, n))
            begin
                if (n % 2 == 0)
                begin
                    rd_data[15:0] = chan_val[n/2][15:0];
                end
                else if (cfg_r[n/2][ltu_pkg::CFG_ACCUM])
                begin
                    rd_data[15:0] = chan_val[n/2][31:16];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Answer one cycle after the request, drop it the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= ltu_pkg::REG_RST;
        end
        else
        begin
            wb_ack_o <= req;
            if (req && !wb_we_i)
            begin
                wb_dat_o <= rd_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Done bits out of a flop
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            done_o <= '0;
        end
        else
        begin
            done_o <= chan_done;
        end
    end

endmodule // ltu_top

`default_nettype wire

// *** verification/ltu_chk.sv ***
// Port checker for the ladder timer unit.
// Assumes a bind onto ltu_top; it sees the top ports only.
`default_nettype none
module ltu_chk (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Bus and results
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [3:0]  done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       take;
    logic       rd_take;
    logic [3:0] run_r;
    logic [3:0] clr_r;
    logic [3:0] acc_r;
    logic [3:0] off_m;
    logic [3:0] clr_m;
    // Accepted requests and channels held at zero
    assign take    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign rd_take = take & ~wb_we_i;
    assign off_m   = ~run_r & ~acc_r;
    assign clr_m   = clr_r & acc_r;
    ////////////////////////////////////////////////////////////////////////////
    // Shadow of scan inputs and modes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            run_r <= 4'h0;
            clr_r <= 4'h0;
            acc_r <= 4'h0;
        end
        else if (take && wb_we_i)
        begin
            if (wb_adr_i == 8'h00 && wb_sel_i[0])
                run_r <= wb_dat_i[3:0];
            if (wb_adr_i == 8'h00 && wb_sel_i[1])
                clr_r <= wb_dat_i[11:8];
            if (wb_adr_i[7:4] == 4'h1 && wb_adr_i[1:0] == 2'h0 && wb_sel_i[0])
                acc_r[wb_adr_i[3:2]] <= wb_dat_i[0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Properties
    property p_ack_next; take |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause; wb_ack_o |-> $past(take); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
    property p_rst;
        disable iff (1'b0) rst_i |=> (!wb_ack_o && done_o == 4'h0 && wb_dat_o == 32'h0);
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_unmap;
        rd_take && (wb_adr_i[1:0] != 2'h0 || wb_adr_i == 8'h08) |=> wb_dat_o == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_dat_hold; !$past(rd_take) |-> $stable(wb_dat_o); endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
    property p_done_rd;
        rd_take && wb_adr_i == 8'h04 ##1 $stable(done_o) ##1 $stable(done_o)
            |-> wb_dat_o == {28'h0, done_o};
    endproperty
    a_done_rd: assert property (p_done_rd) else $error("done read mismatch");
    property p_off;
        (done_o & off_m & $past(off_m) & $past(off_m, 2) & $past(off_m, 4)) == 4'h0;
    endproperty
    a_off: assert property (p_off) else $error("done with input off");
    property p_clr;
        (done_o & clr_m & $past(clr_m) & $past(clr_m, 2) & $past(clr_m, 4)) == 4'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("done while cleared");
endmodule // ltu_chk
`default_nettype wire

// *** verification/ltu_scan_model.sv ***
// Ladder scan model: classic Wishbone master reaching the timer registers.
// Assumes the bench top is ltu_top_tb with n_fail and give_verdict.
`default_nettype none
module ltu_scan_model (
    // Clock and answer
    input wire logic        clk_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_i,
    // Request
    output logic            wb_cyc_o,
    output logic            wb_stb_o,
    output logic            wb_we_o,
    output logic [7:0]      wb_adr_o,
    output logic [3:0]      wb_sel_o,
    output logic [31:0]     wb_dat_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o  = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0;
    end
    // One classic cycle; idle lines show the inverse of the last request
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int i;
        @(posedge clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= w;
        wb_adr_o <= a;
        wb_sel_o <= 4'hf;
        wb_dat_o <= d;
        i = 0;
        do
        begin
            @(posedge clk_i);
            i++;
        end
        while (wb_ack_i !== 1'b1 && i < 64);
        q = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o  <= ~w;
        wb_adr_o <= ~a;
        wb_sel_o <= 4'h0;
        wb_dat_o <= ~d;
        if (wb_ack_i !== 1'b1)
        begin
            ltu_top_tb.n_fail++;
            ltu_top_tb.give_verdict();
        end
    endtask
endmodule // ltu_scan_model
`default_nettype wire

// *** verification/ltu_top_tb.sv ***
// Bench top for the ladder timer unit: scan model, checker bind, scenarios.
// Assumes HUND_CYC of 4, so a 0.01 s step is 4 cycles and 0.1 s is 40.
`default_nettype none
module ltu_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc, stb, we, ack;
    logic [7:0]  adr;
    logic [3:0]  sel, done;
    logic [31:0] wdat, rdat, held;
    int          n_fail = 0;
    int          n_checks = 0;
    logic [7:0]  adrs [9] = '{8'h00, 8'h04, 8'h10, 8'h20, 8'h40, 8'h80, 8'h84, 8'h08, 8'h01};
    always #2.5 clk_i = ~clk_i;
    ltu_top #(.HUND_CYC(4)) ltu_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .done_o(done));
    ltu_scan_model ltu_scan_model_inst (.clk_i(clk_i), .wb_dat_i(rdat), .wb_ack_i(ack),
        .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel),
        .wb_dat_o(wdat));
    ////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ltu_scan_model_inst.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        ltu_scan_model_inst.xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        rd(a, q);
        chk32(what, exp, q);
    endtask
    // Next packed decimal value
    function automatic logic [31:0] bcd_inc(input logic [31:0] v);
        logic [31:0] r;
        r = v;
        for (int k = 0; k < 8; k++)
        begin
            if (r[4*k+:4] != 4'h9)
            begin
                r[4*k+:4] = r[4*k+:4] + 4'h1;
                break;
            end
            r[4*k+:4] = 4'h0;
        end
        return r;
    endfunction
    // Poll a value word, each change one decimal step, until it reaches tgt
    task automatic run_to(input logic [7:0] a, input logic [31:0] start, input logic [31:0] tgt);
        logic [31:0] prev, q;
        prev = start;
        for (int i = 0; i < 20000 && prev !== tgt; i++)
        begin
            rd(a, q);
            if (q !== prev)
                chk32("step", bcd_inc(prev), q);
            prev = q;
        end
        chk32("reached", tgt, prev);
        // A poll that ran out of its bound ends the run here
        if (prev !== tgt)
            give_verdict();
    endtask
    task automatic give_verdict();
        if (n_fail == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (adrs[i]) rd_chk("reset word", adrs[i], 32'h0);
        wr(8'h04, 32'hf);
        rd_chk("done word", 8'h04, 32'h0);
        wr(8'h08, 32'hffffffff);
        rd_chk("unmapped", 8'h08, 32'h0);
        // Fast single timer, preset from memory word 5
        wr(8'h54, 32'h4);
        wr(8'h20, 32'h9999);
        wr(8'h10, 32'h2e);
        wr(8'h00, 32'h1);
        run_to(8'h80, 32'h0, 32'h12);
        rd_chk("done word", 8'h04, 32'h1);
        wr(8'h54, 32'h100);
        rd_chk("done word", 8'h04, 32'h0);
        wr(8'h10, 32'h2);
        rd_chk("done word", 8'h04, 32'h0);
        wr(8'h20, 32'h1);
        rd_chk("done word", 8'h04, 32'h1);
        wr(8'h00, 32'h0);
        rd_chk("value 0", 8'h80, 32'h0);
        // Tenth accumulating timer on channel 1, preset 3
        wr(8'h14, 32'h1);
        wr(8'h24, 32'h3);
        wr(8'h00, 32'h2);
        run_to(8'h88, 32'h0, 32'h2);
        wr(8'h00, 32'h0);
        rd(8'h88, held);
        for (int i = 0; i < 40; i++) rd_chk("held", 8'h88, held);
        chk32("done_o", (held >= 32'h3) ? 32'h2 : 32'h0, {28'h0, done});
        wr(8'h00, 32'h2);
        run_to(8'h88, held, 32'h5);
        chk32("done_o", 32'h2, {28'h0, done});
        wr(8'h00, 32'h202);
        for (int i = 0; i < 20; i++) rd_chk("cleared", 8'h88, 32'h0);
        chk32("done_o", 32'h0, {28'h0, done});
        rd_chk("high word", 8'h8c, 32'h0);
        // Fast single to its limit beside a fast accumulating timer
        wr(8'h18, 32'h2);
        wr(8'h28, 32'h9999);
        wr(8'h1c, 32'h3);
        wr(8'h00, 32'h20c);
        run_to(8'h90, 32'h0, 32'h9999);
        for (int i = 0; i < 10; i++) rd_chk("held max", 8'h90, 32'h9999);
        chk32("done_o", 32'hc, {28'h0, done});
        rd_chk("accum high", 8'h9c, 32'h1);
        wr(8'h2c, 32'h20000);
        rd_chk("done word", 8'h04, 32'h4);
        // Tenth single timer on channel 0, high preset digits ignored
        wr(8'h10, 32'h0);
        wr(8'h20, 32'h10002);
        wr(8'h00, 32'h20d);
        run_to(8'h80, 32'h0, 32'h2);
        rd_chk("done word", 8'h04, 32'h5);
        give_verdict();
    end
endmodule // ltu_top_tb
bind ltu_top ltu_chk ltu_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .done_o(done_o));
`default_nettype wire
